// ===== sdpi_pkg.sv
// Constants, command and power-state types of the synchronous DRAM pin interface.
// Assumes a 16-bit, four-bank part with a fixed burst of four and read latency of two.
package sdpi_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DQ_W   = 16;
  localparam int LANE_W = 8;
  localparam int LANES  = 2;
  localparam int ADDR_W = 12;
  localparam int BA_W   = 2;
  localparam int NBANK  = 4;
  localparam int COL_W  = 8;
  localparam int OP_W   = 14;
  localparam int AP_BIT = 10;

  // ----------------------------------------------------------------
  // Burst and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]       BURST_LAST = 3'h3;
  localparam logic [2:0]       LEFT_RST   = 3'h0;
  localparam logic [NBANK-1:0] OPEN_RST   = 4'h0;
  localparam logic [OP_W-1:0]  MODE_RST   = 14'h0000;

  // ----------------------------------------------------------------
  // Strobe codes {ras_n, cas_n, we_n} with chip select low
  // ----------------------------------------------------------------
  localparam logic [2:0] SIG_LMR  = 3'h0;
  localparam logic [2:0] SIG_AREF = 3'h1;
  localparam logic [2:0] SIG_PRE  = 3'h2;
  localparam logic [2:0] SIG_ACT  = 3'h3;
  localparam logic [2:0] SIG_WR   = 3'h4;
  localparam logic [2:0] SIG_RD   = 3'h5;
  localparam logic [2:0] SIG_BST  = 3'h6;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_AREF, CMD_LMR
  } sdpi_cmd_e;

  typedef enum logic [2:0] {
    PWR_RUN, PWR_SUSP, PWR_PDP, PWR_PDA, PWR_SREF
  } sdpi_pwr_e;

endpackage : sdpi_pkg

// ===== sdpi_cmd_if.sv
// Device-side pin interface of a four-bank synchronous DRAM: command decode, bank
// state, burst counter, byte masking and power-state control.
// Assumes a core array that answers rd_data_in combinationally in the read beat cycle.
// What this block does
// - All inputs but the asynchronous reset are captured only on the rising clock edge.
// - Each edge with ce_in high, in run state with clock enable high, steps the burst column counter while a burst runs and clocks output data registers.
// - Clock enable low: clock suspend during a burst, self refresh with auto refresh, else power-down by bank state.
// - Clock enable is synchronous, power-down and self refresh exits included.
// - In power-down and self refresh all inputs except clock enable are ignored.
// - Chip select low enables the decoder; high masks every new command.
// - Bursts started keep running and byte masks act while chip select is high.
// - Chip select and the three strobes are decoded together at the edge.
// - Write data on a masked byte lane is discarded.
// - Read output lanes go high impedance two edges after mask sampled high.
// - Low mask covers data bits 0 to 7, high mask bits 8 to 15.
// - Bank inputs select the target bank of activate, read, write, precharge.
// - Mode load takes bank and address inputs as the operation code.
// - Activate samples all twelve address bits as the row.
// - Read or write takes the low bits as column; bit 10 asks auto-precharge.
// - Precharge with bit 10 high closes all banks, else only the selected one.
`timescale 1ns/1ps
module sdpi_cmd_if (
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          ce_in,
  input  wire logic                          cke_in,
  input  wire logic                          cs_n_in,
  input  wire logic                          ras_n_in,
  input  wire logic                          cas_n_in,
  input  wire logic                          we_n_in,
  input  wire logic [sdpi_pkg::LANES-1:0]    dqm_in,
  input  wire logic [sdpi_pkg::BA_W-1:0]     ba_in,
  input  wire logic [sdpi_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic [sdpi_pkg::DQ_W-1:0]     dq_in,
  output logic      [sdpi_pkg::DQ_W-1:0]     dq_out,
  output logic      [sdpi_pkg::LANES-1:0]    dq_oe_out,
  input  wire logic [sdpi_pkg::DQ_W-1:0]     rd_data_in,
  output logic                               act_out,
  output logic                               pre_out,
  output logic      [sdpi_pkg::NBANK-1:0]    pre_mask_out,
  output logic                               aref_out,
  output logic                               lmr_out,
  output logic      [sdpi_pkg::OP_W-1:0]     mode_op_out,
  output logic                               rd_en_out,
  output logic                               wr_en_out,
  output logic      [sdpi_pkg::BA_W-1:0]     acc_bank_out,
  output logic      [sdpi_pkg::ADDR_W-1:0]   acc_row_out,
  output logic      [sdpi_pkg::COL_W-1:0]    acc_col_out,
  output logic      [sdpi_pkg::DQ_W-1:0]     wr_data_out,
  output logic      [sdpi_pkg::LANES-1:0]    wr_be_out,
  output logic      [sdpi_pkg::NBANK-1:0]    bank_open_out,
  output logic      [2:0]                    pwr_state_out,
  output logic                               rx_en_out
);

  // ----------------------------------------------------------------
  // Power state and command decode
  // ----------------------------------------------------------------
  sdpi_pkg::sdpi_pwr_e pwr_r;
  sdpi_pkg::sdpi_cmd_e raw_cmd;
  sdpi_pkg::sdpi_cmd_e cmd;
  logic                live;
  logic [2:0]          left_r;
  logic [sdpi_pkg::NBANK-1:0] open_r;

  assign live = (pwr_r == sdpi_pkg::PWR_RUN) && cke_in;
  assign rx_en_out = (pwr_r == sdpi_pkg::PWR_RUN) || (pwr_r == sdpi_pkg::PWR_SUSP);
  assign pwr_state_out = pwr_r;
  assign bank_open_out = open_r;

  always_comb begin
    raw_cmd = sdpi_pkg::CMD_NOP;
    if (!cs_n_in && pwr_r == sdpi_pkg::PWR_RUN) begin
      case ({ras_n_in, cas_n_in, we_n_in})
        sdpi_pkg::SIG_LMR:  raw_cmd = sdpi_pkg::CMD_LMR;
        sdpi_pkg::SIG_AREF: raw_cmd = sdpi_pkg::CMD_AREF;
        sdpi_pkg::SIG_PRE:  raw_cmd = sdpi_pkg::CMD_PRE;
        sdpi_pkg::SIG_ACT:  raw_cmd = sdpi_pkg::CMD_ACT;
        sdpi_pkg::SIG_WR:   raw_cmd = sdpi_pkg::CMD_WR;
        sdpi_pkg::SIG_RD:   raw_cmd = sdpi_pkg::CMD_RD;
        sdpi_pkg::SIG_BST:  raw_cmd = sdpi_pkg::CMD_BST;
        default:            raw_cmd = sdpi_pkg::CMD_NOP;
      endcase
    end
    cmd = live ? raw_cmd : sdpi_pkg::CMD_NOP;
  end

  // Exit from power-down or self refresh needs clock enable high at just one rising edge with ce_in high, so the
  // controller need not hold clock enable across several sampled edges.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwr_r <= sdpi_pkg::PWR_RUN;
    end else if (ce_in) begin
      case (pwr_r)
        sdpi_pkg::PWR_RUN: begin
          if (!cke_in) begin
            if (left_r != sdpi_pkg::LEFT_RST) pwr_r <= sdpi_pkg::PWR_SUSP;
            else if (raw_cmd == sdpi_pkg::CMD_AREF) pwr_r <= sdpi_pkg::PWR_SREF;
            else if (open_r != sdpi_pkg::OPEN_RST) pwr_r <= sdpi_pkg::PWR_PDA;
            else pwr_r <= sdpi_pkg::PWR_PDP;
          end
        end
        sdpi_pkg::PWR_SUSP: begin
          if (cke_in) pwr_r <= sdpi_pkg::PWR_RUN;
        end
        sdpi_pkg::PWR_PDP, sdpi_pkg::PWR_PDA, sdpi_pkg::PWR_SREF: begin
          if (cke_in) pwr_r <= sdpi_pkg::PWR_RUN;
        end
        default: pwr_r <= sdpi_pkg::PWR_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Burst counter
  // ----------------------------------------------------------------
  logic                        new_acc;
  logic                        beat_go;
  logic                        beat_wr;
  logic                        wr_burst_r;
  logic                        ap_r;
  logic [sdpi_pkg::BA_W-1:0]   beat_bank;
  logic [sdpi_pkg::BA_W-1:0]   burst_bank_r;
  logic [sdpi_pkg::COL_W-1:0]  beat_col;
  logic [sdpi_pkg::COL_W-1:0]  next_col;
  logic [sdpi_pkg::COL_W-1:0]  cnt_col_r;
  logic                        ap_close;

  assign new_acc = (cmd == sdpi_pkg::CMD_RD) || (cmd == sdpi_pkg::CMD_WR);

  always_comb begin
    beat_go   = 1'b0;
    beat_wr   = wr_burst_r;
    beat_col  = cnt_col_r;
    beat_bank = burst_bank_r;
    if (new_acc) begin
      beat_go   = 1'b1;
      beat_wr   = (cmd == sdpi_pkg::CMD_WR);
      beat_col  = addr_in[sdpi_pkg::COL_W-1:0];
      beat_bank = ba_in;
    end else if (live && left_r != sdpi_pkg::LEFT_RST && cmd != sdpi_pkg::CMD_BST) begin
      beat_go = 1'b1;
    end
  end

  // Sequential order wraps inside the aligned block of four columns
  assign next_col = {beat_col[sdpi_pkg::COL_W-1:2], beat_col[1:0] + 2'h1};
  assign ap_close = beat_go && !new_acc && left_r == 3'h1 && ap_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      left_r       <= sdpi_pkg::LEFT_RST;
      cnt_col_r    <= '0;
      wr_burst_r   <= 1'b0;
      burst_bank_r <= '0;
      ap_r         <= 1'b0;
    end else if (ce_in) begin
      if (new_acc) begin
        left_r       <= sdpi_pkg::BURST_LAST;
        cnt_col_r    <= next_col;
        wr_burst_r   <= beat_wr;
        burst_bank_r <= ba_in;
        ap_r         <= addr_in[sdpi_pkg::AP_BIT];
      end else if (cmd == sdpi_pkg::CMD_BST) begin
        left_r <= sdpi_pkg::LEFT_RST;
      end else if (beat_go) begin
        left_r    <= left_r - 3'h1;
        cnt_col_r <= next_col;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bank state and core command outputs
  // ----------------------------------------------------------------
  logic [sdpi_pkg::ADDR_W-1:0] row_r [sdpi_pkg::NBANK];

  for (genvar b = 0; b < sdpi_pkg::NBANK; b++) begin : g_bank
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        open_r[b] <= 1'b0;
        row_r[b]  <= '0;
      end else if (ce_in) begin
        if (cmd == sdpi_pkg::CMD_ACT && ba_in == b) begin
          open_r[b] <= 1'b1;
          row_r[b]  <= addr_in;
        end else if (cmd == sdpi_pkg::CMD_PRE
                     && (addr_in[sdpi_pkg::AP_BIT] || ba_in == b)) begin
          open_r[b] <= 1'b0;
        end else if (ap_close && burst_bank_r == b) begin
          open_r[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      act_out      <= 1'b0;
      pre_out      <= 1'b0;
      pre_mask_out <= '0;
      aref_out     <= 1'b0;
      lmr_out      <= 1'b0;
      mode_op_out  <= sdpi_pkg::MODE_RST;
    end else if (ce_in) begin
      act_out  <= (cmd == sdpi_pkg::CMD_ACT);
      pre_out  <= (cmd == sdpi_pkg::CMD_PRE);
      aref_out <= (cmd == sdpi_pkg::CMD_AREF);
      lmr_out  <= (cmd == sdpi_pkg::CMD_LMR);
      if (cmd == sdpi_pkg::CMD_PRE) begin
        pre_mask_out <= addr_in[sdpi_pkg::AP_BIT] ? 4'hf : (4'h1 << ba_in);
      end
      if (cmd == sdpi_pkg::CMD_LMR) mode_op_out <= {ba_in, addr_in};
    end
  end

  // ----------------------------------------------------------------
  // Beat and data path
  // ----------------------------------------------------------------
  // Everything here freezes in clock suspend, so strobes and addresses hold.
  logic [sdpi_pkg::LANES-1:0] dqm_s_r;
  logic [sdpi_pkg::LANES-1:0] dqm_d_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_en_out    <= 1'b0;
      wr_en_out    <= 1'b0;
      acc_bank_out <= '0;
      acc_row_out  <= '0;
      acc_col_out  <= '0;
    end else if (ce_in && live) begin
      rd_en_out <= beat_go && !beat_wr;
      wr_en_out <= beat_go && beat_wr;
      if (cmd == sdpi_pkg::CMD_ACT) begin
        acc_bank_out <= ba_in;
        acc_row_out  <= addr_in;
      end else if (beat_go) begin
        acc_bank_out <= beat_bank;
        acc_row_out  <= row_r[beat_bank];
        acc_col_out  <= beat_col;
      end
    end
  end

  for (genvar l = 0; l < sdpi_pkg::LANES; l++) begin : g_lane
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        wr_data_out[l*sdpi_pkg::LANE_W +: sdpi_pkg::LANE_W] <= '0;
        dq_out[l*sdpi_pkg::LANE_W +: sdpi_pkg::LANE_W]      <= '0;
        wr_be_out[l] <= 1'b0;
        dqm_s_r[l]   <= 1'b0;
        dqm_d_r[l]   <= 1'b0;
        dq_oe_out[l] <= 1'b0;
      end else if (ce_in && live) begin
        wr_data_out[l*sdpi_pkg::LANE_W +: sdpi_pkg::LANE_W] <=
          dq_in[l*sdpi_pkg::LANE_W +: sdpi_pkg::LANE_W];
        wr_be_out[l] <= beat_go && beat_wr && !dqm_in[l];
        dqm_s_r[l]   <= dqm_in[l];
        dqm_d_r[l]   <= dqm_s_r[l];
        if (rd_en_out) begin
          dq_out[l*sdpi_pkg::LANE_W +: sdpi_pkg::LANE_W] <=
            rd_data_in[l*sdpi_pkg::LANE_W +: sdpi_pkg::LANE_W];
        end
        dq_oe_out[l] <= rd_en_out && !dqm_d_r[l];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_live;
    ce_in && live;
  endsequence
  sequence s_desel;
    ce_in && live && cs_n_in;
  endsequence
  sequence s_wr_cmd;
    ce_in && live && !cs_n_in && {ras_n_in, cas_n_in, we_n_in} == sdpi_pkg::SIG_WR;
  endsequence

  AST_DQM_HIZ: assert property (
    (s_live and dqm_in[0]) ##1 s_live ##1 s_live |=> !dq_oe_out[0])
    else $error("read lane 0 still driven two edges after mask");
  AST_CS_MASK: assert property (
    ce_in && cs_n_in |=> !act_out && !pre_out && !lmr_out && !aref_out)
    else $error("command taken with chip select high");
  AST_WR_MASK: assert property (
    s_wr_cmd and dqm_in[1] |=> wr_en_out && !wr_be_out[1] && acc_col_out == $past(addr_in[7:0]))
    else $error("masked upper lane written");
  AST_ACT_ROW: assert property (
    (s_live and !cs_n_in && {ras_n_in, cas_n_in, we_n_in} == sdpi_pkg::SIG_ACT)
    |=> act_out && acc_row_out == $past(addr_in) && acc_bank_out == $past(ba_in)
        && bank_open_out[acc_bank_out])
    else $error("activate row or bank wrong");
  AST_PRE_ALL: assert property (
    (s_live and !cs_n_in && addr_in[10] && {ras_n_in, cas_n_in, we_n_in} == sdpi_pkg::SIG_PRE)
    |=> pre_out && pre_mask_out == 4'hf && bank_open_out == 4'h0)
    else $error("precharge all left a bank open");
  AST_BURST_RUN: assert property (
    s_wr_cmd ##1 s_desel ##1 s_desel ##1 s_desel
    |=> wr_en_out && $past(wr_en_out) && $past(wr_en_out, 2) && $past(wr_en_out, 3))
    else $error("write burst stopped under chip select high");
  AST_COL_STEP: assert property (
    (s_wr_cmd and addr_in[1:0] == 2'h0) ##1 s_desel
    |=> acc_col_out == $past(addr_in[7:0], 2) + 8'h01)
    else $error("burst column did not advance");
  AST_SUSPEND: assert property (
    ce_in && pwr_r == sdpi_pkg::PWR_RUN && left_r != 3'h0 && !cke_in
    |=> pwr_state_out == sdpi_pkg::PWR_SUSP [*1] ##1 (!ce_in || cke_in || rd_en_out == $past(rd_en_out)))
    else $error("clock suspend not entered or not frozen");
  AST_PD_EXIT: assert property (
    ce_in && cke_in && (pwr_r == sdpi_pkg::PWR_PDP || pwr_r == sdpi_pkg::PWR_SREF)
    |=> pwr_state_out == sdpi_pkg::PWR_RUN)
    else $error("power-down not left on clock enable high");
  AST_RX_OFF: assert property (
    pwr_r == sdpi_pkg::PWR_SREF && ce_in |-> !rx_en_out ##1 !act_out && !lmr_out)
    else $error("inputs obeyed in self refresh");
  AST_LMR_OP: assert property (
    (s_live and !cs_n_in && {ras_n_in, cas_n_in, we_n_in} == sdpi_pkg::SIG_LMR)
    |=> lmr_out && mode_op_out == $past({ba_in, addr_in}))
    else $error("mode operation code not stored");
  AST_AUTO_PRE: assert property (
    (s_wr_cmd and addr_in[10]) ##1 s_desel ##1 s_desel ##1 s_desel
    |=> !bank_open_out[$past(ba_in, 4)])
    else $error("auto-precharge did not close the bank");

endmodule : sdpi_cmd_if

// ===== sdpi_ctrl_model.sv
// Memory controller model that drives the pin side of the DRAM interface.
// Assumes the bench calls its tasks; every pin changes on the falling edge.
`timescale 1ns/1ps
module sdpi_ctrl_model (
  input  wire logic        clk_in,
  output logic             ce_out,
  output logic             cke_out,
  output logic             cs_n_out,
  output logic [2:0]       code_out,
  output logic [1:0]       dqm_out,
  output logic [1:0]       ba_out,
  output logic [11:0]      addr_out,
  output logic [15:0]      dq_out
);
  // Strobes, bank and address stay unknown until the first command; chip select
  // high keeps them out of the decoder until then.
  initial begin
    ce_out = 1'b1;
    cke_out = 1'b1;
    cs_n_out = 1'b1;
    dqm_out = 2'h0;
    dq_out = 16'h0000;
  end
  // Strobe code {ras, cas, we} with chip select, bank and address together
  task automatic cmd(input logic cs, input logic [2:0] c, input logic [1:0] b,
                     input logic [11:0] a, input logic [15:0] d, input logic [1:0] m);
    @(negedge clk_in);
    cs_n_out = cs;
    code_out = c;
    ba_out = b;
    addr_out = a;
    dq_out = d;
    dqm_out = m;
  endtask : cmd
  // Deselected cycle; a released data bus shows no stale value
  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    @(negedge clk_in);
    cs_n_out = 1'b1;
    code_out = 3'h7;
    dq_out = d;
    dqm_out = m;
  endtask : beat
  task automatic idle();
    beat(~dq_out, 2'h0);
  endtask : idle
  // Exit of power-down is a plain level change, taken at the next rising edge with ce_in high
  task automatic set_cke(input logic v);
    cke_out = v;
  endtask : set_cke
  // Block-wide clock enable, changed only just after a falling edge
  task automatic set_ce(input logic v);
    ce_out = v;
  endtask : set_ce
endmodule : sdpi_ctrl_model

// ===== tb_sdpi_cmd_if.sv
// Self-checking bench of the DRAM pin interface.
// Assumes the controller model drives pins and a core stub answers reads.
`timescale 1ns/1ps
module tb_sdpi_cmd_if;
  logic clk_in, rst_n_in, ce, cke, cs_n;
  logic [2:0] code;
  logic [1:0] dqm, ba, dq_oe;
  logic [11:0] addr, acc_row;
  logic [15:0] dq_w, dq_r, rd_data, wr_data;
  logic [7:0] acc_col;
  logic [1:0] acc_bank, wr_be;
  logic [3:0] pre_mask, bank_open;
  logic [13:0] mode_op;
  logic act, pre, aref, lmr, rd_en, wr_en, rx_en;
  logic [2:0] pwr;
  int err_count, n_checks, cyc;
  // Core stub: read data names its own column
  assign rd_data = {8'h5a, acc_col};
  sdpi_ctrl_model sdpi_ctrl_model_i (.clk_in(clk_in), .ce_out(ce), .cke_out(cke),
    .cs_n_out(cs_n), .code_out(code), .dqm_out(dqm), .ba_out(ba), .addr_out(addr),
    .dq_out(dq_w));
  sdpi_cmd_if sdpi_cmd_if_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .cke_in(cke),
    .cs_n_in(cs_n), .ras_n_in(code[2]), .cas_n_in(code[1]), .we_n_in(code[0]),
    .dqm_in(dqm), .ba_in(ba), .addr_in(addr), .dq_in(dq_w), .dq_out(dq_r),
    .dq_oe_out(dq_oe), .rd_data_in(rd_data), .act_out(act), .pre_out(pre),
    .pre_mask_out(pre_mask), .aref_out(aref), .lmr_out(lmr), .mode_op_out(mode_op),
    .rd_en_out(rd_en), .wr_en_out(wr_en), .acc_bank_out(acc_bank), .acc_row_out(acc_row),
    .acc_col_out(acc_col), .wr_data_out(wr_data), .wr_be_out(wr_be),
    .bank_open_out(bank_open), .pwr_state_out(pwr), .rx_en_out(rx_en));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // A hang costs at most this many cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic t_reset();
    chk("pwr", 16'(pwr), 16'h0);
    chk("rx_en", 16'(rx_en), 16'h1);
    chk("bank_open", 16'(bank_open), 16'h0);
  endtask : t_reset
  task automatic t_act_cs();
    sdpi_ctrl_model_i.cmd(1'b0, 3'h3, 2'h2, 12'habc, 16'h0, 2'h0);
    sdpi_ctrl_model_i.cmd(1'b1, 3'h3, 2'h1, 12'h123, 16'h0, 2'h0);
    chk("act", 16'(act), 16'h1);
    chk("acc_row", 16'(acc_row), 16'habc);
    chk("acc_bank", 16'(acc_bank), 16'h2);
    sdpi_ctrl_model_i.idle();
    chk("act_masked", 16'(act), 16'h0);
    chk("bank_open", 16'(bank_open), 16'h4);
  endtask : t_act_cs
  task automatic t_write();
    sdpi_ctrl_model_i.cmd(1'b0, 3'h4, 2'h2, 12'h005, 16'h1111, 2'h2);
    for (int i = 0; i < 4; i++) begin
      sdpi_ctrl_model_i.beat(16'h1111 * 16'(i + 2), 2'h0);
      chk("wr_en", 16'(wr_en), 16'h1);
      chk("wr_col", 16'(acc_col), {8'h0, 6'h01, 2'(i + 1)});
      chk("wr_data", wr_data, 16'h1111 * 16'(i + 1));
      chk("wr_be", 16'(wr_be), (i == 0) ? 16'h1 : 16'h3);
    end
    sdpi_ctrl_model_i.idle();
    chk("wr_end", 16'(wr_en), 16'h0);
  endtask : t_write
  task automatic t_read_ap();
    sdpi_ctrl_model_i.cmd(1'b0, 3'h5, 2'h2, 12'h40a, 16'h0, 2'h0);
    sdpi_ctrl_model_i.beat(16'hffff, 2'h1);
    chk("rd_en", 16'(rd_en), 16'h1);
    chk("rd_col", 16'(acc_col), 16'h0a);
    sdpi_ctrl_model_i.beat(16'h0000, 2'h0);
    chk("dq0", dq_r, 16'h5a0a);
    chk("oe0", 16'(dq_oe), 16'h3);
    sdpi_ctrl_model_i.idle();
    chk("dq1", dq_r, 16'h5a0b);
    chk("oe1", 16'(dq_oe), 16'h3);
    sdpi_ctrl_model_i.idle();
    chk("oe2", 16'(dq_oe), 16'h2);
    chk("dq2_hi", 16'(dq_r[15:8]), 16'h5a);
    sdpi_ctrl_model_i.idle();
    sdpi_ctrl_model_i.idle();
    chk("auto_pre", 16'(bank_open), 16'h0);
  endtask : t_read_ap
  task automatic t_pre_pwr();
    sdpi_ctrl_model_i.cmd(1'b0, 3'h3, 2'h0, 12'h001, 16'h0, 2'h0);
    sdpi_ctrl_model_i.cmd(1'b0, 3'h3, 2'h1, 12'h002, 16'h0, 2'h0);
    sdpi_ctrl_model_i.cmd(1'b0, 3'h2, 2'h1, 12'h000, 16'h0, 2'h0);
    sdpi_ctrl_model_i.idle();
    chk("pre", 16'(pre), 16'h1);
    chk("pre_one", 16'(pre_mask), 16'h2);
    chk("open_one", 16'(bank_open), 16'h1);
    sdpi_ctrl_model_i.set_cke(1'b0);
    sdpi_ctrl_model_i.cmd(1'b0, 3'h3, 2'h3, 12'h004, 16'h0, 2'h0);
    sdpi_ctrl_model_i.idle();
    chk("pd_act", 16'(pwr), 16'h3);
    chk("rx_off", 16'(rx_en), 16'h0);
    chk("pd_ignore", 16'(bank_open), 16'h1);
    sdpi_ctrl_model_i.set_cke(1'b1);
    sdpi_ctrl_model_i.idle();
    chk("pd_exit", 16'(pwr), 16'h0);
    sdpi_ctrl_model_i.cmd(1'b0, 3'h2, 2'h0, 12'h400, 16'h0, 2'h0);
    sdpi_ctrl_model_i.idle();
    chk("pre_all", 16'(pre_mask), 16'hf);
    chk("open_none", 16'(bank_open), 16'h0);
    sdpi_ctrl_model_i.set_cke(1'b0);
    sdpi_ctrl_model_i.idle();
    chk("pd_pre", 16'(pwr), 16'h2);
    sdpi_ctrl_model_i.set_cke(1'b1);
    sdpi_ctrl_model_i.cmd(1'b0, 3'h1, 2'h0, 12'h000, 16'h0, 2'h0);
    sdpi_ctrl_model_i.set_cke(1'b0);
    sdpi_ctrl_model_i.idle();
    chk("sref", 16'(pwr), 16'h4);
    sdpi_ctrl_model_i.set_cke(1'b1);
    sdpi_ctrl_model_i.idle();
    chk("sref_exit", 16'(pwr), 16'h0);
  endtask : t_pre_pwr
  task automatic t_misc();
    sdpi_ctrl_model_i.cmd(1'b0, 3'h0, 2'h3, 12'h5a5, 16'h0, 2'h0);
    sdpi_ctrl_model_i.cmd(1'b0, 3'h1, 2'h0, 12'h000, 16'h0, 2'h0);
    chk("lmr", 16'(lmr), 16'h1);
    chk("mode_op", 16'(mode_op), 16'h35a5);
    sdpi_ctrl_model_i.idle();
    chk("aref", 16'(aref), 16'h1);
    sdpi_ctrl_model_i.cmd(1'b0, 3'h3, 2'h0, 12'h010, 16'h0, 2'h0);
    sdpi_ctrl_model_i.cmd(1'b0, 3'h5, 2'h0, 12'h000, 16'h0, 2'h0);
    sdpi_ctrl_model_i.idle();
    chk("s_col", 16'(acc_col), 16'h00);
    sdpi_ctrl_model_i.set_cke(1'b0);
    sdpi_ctrl_model_i.idle();
    chk("susp", 16'(pwr), 16'h1);
    chk("susp_col", 16'(acc_col), 16'h00);
    chk("susp_rd", 16'(rd_en), 16'h1);
    sdpi_ctrl_model_i.set_cke(1'b1);
    sdpi_ctrl_model_i.cmd(1'b0, 3'h6, 2'h0, 12'h000, 16'h0, 2'h0);
    sdpi_ctrl_model_i.idle();
    sdpi_ctrl_model_i.idle();
    chk("bst", 16'(rd_en), 16'h0);
    chk("run", 16'(pwr), 16'h0);
  endtask : t_misc
  task automatic t_ce_ap();
    sdpi_ctrl_model_i.cmd(1'b0, 3'h3, 2'h1, 12'h077, 16'h0, 2'h0);
    sdpi_ctrl_model_i.cmd(1'b0, 3'h4, 2'h1, 12'h404, 16'h6666, 2'h0);
    chk("ap_open", 16'(bank_open), 16'h3);
    sdpi_ctrl_model_i.beat(16'h7777, 2'h0);
    chk("ap_col0", 16'(acc_col), 16'h04);
    sdpi_ctrl_model_i.beat(16'h8888, 2'h0);
    chk("ap_col1", 16'(acc_col), 16'h05);
    chk("ap_data1", wr_data, 16'h7777);
    sdpi_ctrl_model_i.beat(16'h9999, 2'h0);
    sdpi_ctrl_model_i.idle();
    chk("ap_close", 16'(bank_open), 16'h1);
    // Clock enable low must hold the pulse and ignore the precharge on the pins
    sdpi_ctrl_model_i.cmd(1'b0, 3'h3, 2'h2, 12'h0aa, 16'h0, 2'h0);
    sdpi_ctrl_model_i.cmd(1'b0, 3'h2, 2'h0, 12'h400, 16'h0, 2'h0);
    sdpi_ctrl_model_i.set_ce(1'b0);
    chk("ce_act", 16'(act), 16'h1);
    sdpi_ctrl_model_i.idle();
    chk("ce_hold", 16'(act), 16'h1);
    chk("ce_open", 16'(bank_open), 16'h5);
    sdpi_ctrl_model_i.set_ce(1'b1);
    sdpi_ctrl_model_i.idle();
    chk("ce_run", 16'(act), 16'h0);
  endtask : t_ce_ap
  initial begin
    rst_n_in = 1'b0;
    err_count = 0;
    n_checks = 0;
    repeat (5) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset();
    t_act_cs();
    t_write();
    t_read_ap();
    t_pre_pwr();
    t_misc();
    t_ce_ap();
    tally_and_finish();
  end
endmodule : tb_sdpi_cmd_if
